/* File: dv/psl_assertions.sv */
`default_nettype none
module psl_assertions
   import psl_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic load_strobe,
   input wire logic power_enable,
   input wire logic lock_indication,
   input wire psl_word_t ref_latch,
   input wire psl_word_t feedback_latch,
   input wire psl_word_t function_latch,
   input wire logic init_pulse,
   input wire logic feedback_pulse,
   input wire logic output_active,
   input wire logic powered_down,
   input wire logic monitor_output
);
   timeunit 1ns;
   timeprecision 1ps;
   // synchronisers need a few edges after reset before their lag holds
   logic [2:0] up_reg;
   always_ff @(posedge core_clk) up_reg <= reset ? 3'h0 : up_reg + 3'(up_reg != 3'h7);
   wire ok = up_reg > 3'h3;
   wire [71:0] lat = {ref_latch, feedback_latch, function_latch};
   // cycles since the last latch update, saturating well above the minimum spacing
   logic [7:0] gap_reg;
   always_ff @(posedge core_clk) begin
      if (reset) gap_reg <= 8'hff;
      else if ($changed(lat)) gap_reg <= 8'h0;
      else if (gap_reg != 8'hff) gap_reg <= gap_reg + 8'h1;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   a_pd_lag: assert property (ok |-> powered_down == !$past(power_enable, 3))
      else $error("power-down flag lag wrong");
   a_mon_lock: assert property (ok && $past(function_latch[6:4]) == SEL_LOCK
      |-> monitor_output == $past(lock_indication, 3)) else $error("monitor not lock");
   a_commit_time: assert property ($changed(lat) |-> $past(load_strobe, 2)
      && !$past(load_strobe, 5)) else $error("latch moved without strobe rise");
   a_init_once: assert property (init_pulse |=> !init_pulse) else $error("init pulse long");
   a_fb_once: assert property (feedback_pulse |=> !feedback_pulse) else $error("fb pulse long");
   a_init_cause: assert property (init_pulse |-> $past(load_strobe, 2)
      && !$past(load_strobe, 5)) else $error("init pulse without load");
   a_fb_cause: assert property (feedback_pulse |-> $past(load_strobe, 2))
      else $error("feedback pulse without load");
   a_active_power: assert property (output_active |-> !powered_down)
      else $error("active while powered down");
   a_update_gap: assert property ($changed(lat) |-> gap_reg >= 8'(UPDATE_MIN_CYCLES - 1))
      else $error("latch updates closer than the minimum spacing");
   cover property (init_pulse);
   cover property (feedback_pulse);
   cover property ($rose(output_active));
endmodule
bind psl_serial_load_port psl_assertions chk_i (.*);
`default_nettype wire

/* File: dv/psl_host_model.sv */
`default_nettype none
module psl_host_model (
   output logic serial_clk,
   output logic serial_data,
   output logic load_strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      serial_clk = 1'b0;
      serial_data = 1'b0;
      load_strobe = 1'b1;
   end
   // clock stands low between frames; the data line flips so a stale bit never looks held
   task automatic send(input logic [23:0] w);
      #($urandom_range(19, 1)) load_strobe = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         serial_data = w[i];
         #32 serial_clk = 1'b1;
         #32 serial_clk = 1'b0;
      end
      serial_data = ~w[0];
      #32 load_strobe = 1'b1;
      // edges with the strobe high must leave the word alone while it is committed
      repeat (2) begin
         serial_data = 1'($urandom());
         #32 serial_clk = 1'b1;
         #32 serial_clk = 1'b0;
      end
      #200;
   endtask
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import psl_pkg::*;
   logic core_clk = 1'b0, reset = 1'b1, power_enable = 1'b1, lock_indication = 1'b0;
   logic [SRC_W-1:0] monitor_sources = '0;
   logic serial_clk, serial_data, load_strobe, init_pulse, feedback_pulse;
   logic output_active, powered_down, monitor_output;
   psl_word_t ref_latch, feedback_latch, function_latch, w;
   psl_word_t expv[3] = '{default: '0};
   int num_errors = 0, n_compared = 0;
   int n_init = 0, n_fb = 0, exp_init = 0, exp_fb = 0;
   bit fb_armed = 1'b0;
   initial forever #10 core_clk = ~core_clk;
   // pulses stand one cycle, so they are counted on every edge and the counts compared
   always @(posedge core_clk) begin
      if (init_pulse === 1'b1) n_init++;
      if (feedback_pulse === 1'b1) n_fb++;
   end
   psl_host_model host (.serial_clk, .serial_data, .load_strobe);
   psl_serial_load_port uut (.core_clk, .reset, .serial_clk, .serial_data, .load_strobe,
      .power_enable, .lock_indication, .monitor_sources, .ref_latch, .feedback_latch,
      .function_latch, .init_pulse, .feedback_pulse, .output_active, .powered_down,
      .monitor_output);
   task automatic chk(input psl_word_t got, input psl_word_t exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic finish_test;
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // strobe stays high at least 16 cycles after each word, past the commit latency
   task automatic wr(input logic [1:0] a, input logic [2:0] sel);
      w = psl_word_t'($urandom());
      w[6:4] = sel;
      w[1:0] = a;
      host.send(w);
      expv[a == 2'h3 ? 2 : a] = w;
      if (a == 2'h3) begin
         exp_init++;
         fb_armed = 1'b1;
      end else if (a == 2'h1 && fb_armed) begin
         exp_fb++;
         fb_armed = 1'b0;
      end
      repeat (2) @(posedge core_clk);
      #1 chk(ref_latch, expv[0]);
      chk(feedback_latch, expv[1]);
      chk(function_latch, expv[2]);
      chk(24'(n_init), 24'(exp_init));
      chk(24'(n_fb), 24'(exp_fb));
   endtask
   initial begin
      void'($urandom(66125));
      repeat (4) @(posedge core_clk);
      #1 reset = 1'b0;
      repeat (3) @(posedge core_clk);
      wr(2'h3, SEL_LOCK);
      wr(2'h0, SEL_LOCK);
      chk({23'h0, output_active}, 24'h0);
      wr(2'h1, SEL_LOCK);
      chk({23'h0, output_active}, 24'h1);
      $display("power-up test done");
      for (int i = 0; i < 8; i++) wr(2'(i), 3'($urandom()));
      $display("address test done");
      @(posedge core_clk) #1 power_enable = 1'b0;
      wr(2'h0, 3'h0);
      chk({22'h0, powered_down, output_active}, 24'h2);
      @(posedge core_clk) #1 power_enable = 1'b1;
      $display("power-down test done");
      for (int s = 0; s < 8; s++) begin
         logic mon_exp;
         wr(2'h2, 3'(s));
         @(posedge core_clk) #1 lock_indication = 1'($urandom());
         monitor_sources = SRC_W'($urandom());
         mon_exp = (s == int'(SEL_LOCK)) ? lock_indication : monitor_sources[s];
         repeat (5) @(posedge core_clk);
         #1 chk({23'h0, monitor_output}, {23'h0, mon_exp});
      end
      $display("monitor test done");
      finish_test();
   end
   initial begin
      #1000000;
      num_errors++;
      finish_test();
   end
endmodule
`default_nettype wire

/* File: src/psl_pkg.sv */
// Functional notes
// - strobe rise moves the whole 24-bit input word into the addressed latch
// - one data bit is shifted in on every rising serial clock edge while the strobe is low
// - serial clock at most 20 MHz, so one update takes at least 1.2 us
// - monitor output selects one of several internal signals, lock indication included
// - two low bits pick latch: 00 ref, 01 feedback, 10 function, 11 init
// - input register keeps accepting and latching words while powered down
`default_nettype none
package psl_pkg;
   localparam int WORD_W = 24;
   localparam int ADDR_W = 2;
   localparam int SEL_W = 3;
   localparam int SEL_LSB = 4;
   localparam int SYNC_STAGES = 2;
   localparam int SRC_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_REF = 2'h0;
   localparam logic [ADDR_W-1:0] ADDR_FEEDBACK = 2'h1;
   localparam logic [ADDR_W-1:0] ADDR_FUNCTION = 2'h2;
   localparam logic [ADDR_W-1:0] ADDR_INIT = 2'h3;
   localparam logic [SEL_W-1:0] SEL_LOCK = 3'h1;
   localparam logic [WORD_W-1:0] LATCH_RESET = 24'h000000;
   localparam real SCLK_MAX_MHZ = 20.0;
   localparam real UPDATE_MIN_US = 1.2;
   localparam real CORE_MHZ = 50.0;
   localparam int UPDATE_MIN_CYCLES = int'($ceil(UPDATE_MIN_US * CORE_MHZ));
   typedef logic [WORD_W-1:0] psl_word_t;
endpackage
`default_nettype wire

/* File: src/psl_serial_load_port.sv */
`default_nettype none
module psl_serial_load_port (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic load_strobe,
   input wire logic power_enable,
   input wire logic lock_indication,
   input wire logic [psl_pkg::SRC_W-1:0] monitor_sources,
   output logic [psl_pkg::WORD_W-1:0] ref_latch,
   output logic [psl_pkg::WORD_W-1:0] feedback_latch,
   output logic [psl_pkg::WORD_W-1:0] function_latch,
   output logic init_pulse,
   output logic feedback_pulse,
   output logic output_active,
   output logic powered_down,
   output logic monitor_output
);
   import psl_pkg::*;

   // link domain: plain shifter, data only, so it needs no reset
   typedef struct packed {
      psl_word_t shifter;
   } psl_link_state_t;
   psl_link_state_t link_reg;
   psl_link_state_t link_next;

   always_comb begin
      link_next = link_reg;
      if (!load_strobe) begin
         link_next.shifter = {link_reg.shifter[WORD_W-2:0], serial_data};
      end
   end
   always_ff @(posedge serial_clk) begin
      link_reg <= link_next;
   end

   // strobe high freezes the shifter, so its word is quasi-static when the
   // synchronised rise is seen; a host that clocks too fast breaks this
   logic strobe_sync;
   logic enable_sync;
   logic lock_sync;
   logic [SRC_W-1:0] src_sync;
   psl_sync #(.WIDTH(1)) u_sync_strobe (
      .core_clk(core_clk),
      .reset(reset),
      .async_in(load_strobe),
      .sync_out(strobe_sync)
   );

   psl_sync #(.WIDTH(1)) u_sync_enable (
      .core_clk(core_clk),
      .reset(reset),
      .async_in(power_enable),
      .sync_out(enable_sync)
   );

   psl_sync #(.WIDTH(1)) u_sync_lock (
      .core_clk(core_clk),
      .reset(reset),
      .async_in(lock_indication),
      .sync_out(lock_sync)
   );

   psl_sync #(.WIDTH(SRC_W)) u_sync_src (
      .core_clk(core_clk),
      .reset(reset),
      .async_in(monitor_sources),
      .sync_out(src_sync)
   );

   // the synchronisers read zero just after reset, so an idle high strobe would
   // look like a fresh rise; commits wait until every stage holds the pin level
   localparam int SETTLE_CYCLES = SYNC_STAGES + 1;
   localparam logic [1:0] SETTLE_DONE = 2'(SETTLE_CYCLES);

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_INIT_DONE = 3'h2,
      ST_ARMED = 3'h4
   } psl_init_state_t;

   typedef struct packed {
      logic strobe_prev;
      logic [1:0] settle;
      psl_word_t ref_latch;
      psl_word_t feedback_latch;
      psl_word_t function_latch;
      logic init_pulse;
      logic feedback_pulse;
      logic ref_loaded;
      logic feedback_loaded;
      logic init_loaded;
      logic output_active;
      logic powered_down;
      logic monitor;
      psl_init_state_t init_state;
   } psl_core_state_t;
   psl_core_state_t core_reg;
   psl_core_state_t core_next;

   always_comb begin
      logic [SRC_W-1:0] sources;
      logic [SEL_W-1:0] sel;
      logic [ADDR_W-1:0] addr;
      logic commit;
      logic fb_load;
      logic init_load;
      logic all_loaded;
      sources = src_sync;
      sel = core_reg.function_latch[SEL_LSB +: SEL_W];
      addr = link_reg.shifter[ADDR_W-1:0];
      commit = 1'b0;
      fb_load = 1'b0;
      init_load = 1'b0;
      all_loaded = 1'b0;
      core_next = core_reg;
      core_next.strobe_prev = strobe_sync;
      core_next.init_pulse = 1'b0;
      core_next.feedback_pulse = 1'b0;

      if (core_reg.settle != SETTLE_DONE) begin
         core_next.settle = core_reg.settle + 2'h1;
      end
      commit = strobe_sync && !core_reg.strobe_prev && (core_reg.settle == SETTLE_DONE);
      // latching keeps running regardless of power state
      if (commit) begin
         case (addr)
            ADDR_REF: begin
               core_next.ref_latch = link_reg.shifter;
               core_next.ref_loaded = 1'b1;
            end
            ADDR_FEEDBACK: begin
               core_next.feedback_latch = link_reg.shifter;
               core_next.feedback_loaded = 1'b1;
               fb_load = 1'b1;
            end
            ADDR_FUNCTION: begin
               core_next.function_latch = link_reg.shifter;
            end
            ADDR_INIT: begin
               core_next.function_latch = link_reg.shifter;
               core_next.init_pulse = 1'b1;
               core_next.init_loaded = 1'b1;
               init_load = 1'b1;
            end
            default: begin
               core_next.function_latch = core_reg.function_latch;
            end
         endcase
      end

      // only the first feedback load after an init repeats the counter reset
      case (core_reg.init_state)
         ST_IDLE: begin
            if (init_load) begin
               core_next.init_state = ST_INIT_DONE;
            end
         end
         ST_INIT_DONE: begin
            // a repeated init load keeps waiting for its feedback load
            if (fb_load) begin
               core_next.feedback_pulse = 1'b1;
               core_next.init_state = ST_ARMED;
            end
         end
         ST_ARMED: begin
            if (init_load) begin
               core_next.init_state = ST_INIT_DONE;
            end
         end
         default: begin
            core_next.init_state = ST_IDLE;
         end
      endcase

      all_loaded = core_reg.ref_loaded && core_reg.feedback_loaded && core_reg.init_loaded;
      core_next.output_active = all_loaded && enable_sync;

      core_next.powered_down = !enable_sync;
      // select one shows the lock indication, the others index the synchronised sources
      if (sel == SEL_LOCK) begin
         core_next.monitor = lock_sync;
      end else begin
         core_next.monitor = sources[sel];
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         core_reg <= '{
            strobe_prev: 1'b1,
            settle: 2'h0,
            ref_latch: LATCH_RESET,
            feedback_latch: LATCH_RESET,
            function_latch: LATCH_RESET,
            init_pulse: 1'b0,
            feedback_pulse: 1'b0,
            ref_loaded: 1'b0,
            feedback_loaded: 1'b0,
            init_loaded: 1'b0,
            output_active: 1'b0,
            powered_down: 1'b1,
            monitor: 1'b0,
            init_state: ST_IDLE
         };
      end else begin
         core_reg <= core_next;
      end
   end

   // every output comes straight from a core register
   assign ref_latch = core_reg.ref_latch;
   assign feedback_latch = core_reg.feedback_latch;
   assign function_latch = core_reg.function_latch;
   assign init_pulse = core_reg.init_pulse;
   assign feedback_pulse = core_reg.feedback_pulse;
   assign output_active = core_reg.output_active;
   assign powered_down = core_reg.powered_down;
   assign monitor_output = core_reg.monitor;
endmodule
`default_nettype wire

/* File: src/psl_sync.sv */
`default_nettype none
module psl_sync #(
   parameter int WIDTH = 1
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   import psl_pkg::*;
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } psl_sync_state_t;
   psl_sync_state_t state_reg;
   psl_sync_state_t state_next;
   // first stage feeds only the second stage
   always_comb begin
      state_next = state_reg;
      state_next.meta = async_in;
      state_next.stable = state_reg.meta;
   end
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end
   assign sync_out = state_reg.stable;
endmodule
`default_nettype wire
